/* verilog/ext_exec_pkg.sv */
/*
  Constants and types for the extended-instruction executor: opcode fields,
  operand widths, instruction-cycle phases and reset values.
  Assumes a core that fetches one 16-bit program word per instruction cycle.
*/
package ext_exec_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int unsigned WORD_W  = 16;
    localparam int unsigned FP_W    = 14;
    localparam int unsigned PC_W    = 21;
    localparam int unsigned DADDR_W = 12;
    localparam int unsigned DATA_W  = 8;
    localparam int unsigned K_W     = 6;
    localparam int unsigned ZS_W    = 7;

    ////////////////////////////////////////////////////////////////////////////
    // opcode fields
    localparam int unsigned   OPC_HI_LSB       = 8;
    localparam int unsigned   OPC_TAG_LSB      = 6;
    localparam int unsigned   OPC_ZS_TAG_BIT   = 7;
    localparam int unsigned   OPC_NIB_LSB      = 12;
    localparam logic [7:0]    OPC_ADD_RET_HI   = 8'hE8;
    localparam logic [1:0]    OPC_ADD_RET_TAG  = 2'h3;
    localparam logic [7:0]    OPC_MOVE_HI      = 8'hEB;
    localparam logic          OPC_MOVE_ZS_TAG  = 1'h0;
    localparam logic [3:0]    OPC_TRAIL_NIB    = 4'hF;

    ////////////////////////////////////////////////////////////////////////////
    // four phases of one instruction cycle
    localparam logic [1:0] PH_DECODE = 2'h0;
    localparam logic [1:0] PH_READ   = 2'h1;
    localparam logic [1:0] PH_PROC   = 2'h2;
    localparam logic [1:0] PH_WRITE  = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [1:0]         PH_RESET   = 2'h0;
    localparam logic [FP_W-1:0]    FP_RESET   = 14'h0000;
    localparam logic [PC_W-1:0]    PC_RESET   = 21'h000000;
    localparam logic [DADDR_W-1:0] ADDR_RESET = 12'h000;
    localparam logic [DATA_W-1:0]  DATA_RESET = 8'h00;
    localparam logic [ZS_W-1:0]    OPND_RESET = 7'h00;

    typedef enum logic [2:0] {
        ST_FETCH,
        ST_ADD_EXEC,
        ST_ADD_NOP,
        ST_MOVE_SRC,
        ST_MOVE_DEST
    } exec_state_t;

endpackage

/* verilog/extended_stack_instr_exec.sv */
/*
  Executor for the add-literal-and-return and the indexed move instructions.
  Owns the frame pointer, runs its own four-phase counter on core_clk_i,
  issues a program counter load with return-stack pop, and reads/writes
  the lower 4 Kbyte data space.
  Assumes: a program word is presented in the decode phase with instr_valid_i;
  data memory returns read data on the clock after mem_rd_o; the core leaves
  every word to this block while busy_o is high and applies pc_load_o.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// - add six-bit unsigned literal to frame pointer
// - in the same clock, load program counter from return stack
// - one word, two cycles, second cycle idle
// - move source is frame pointer plus offset
// - second word gives twelve-bit destination, written last
// - move addresses confined to lower 4 Kbyte
// - move takes two words and two cycles
// - decode only with extended mode enabled
// - lone trailing word executes as no-operation
module extended_stack_instr_exec (
    input  wire logic                            core_clk_i,
    input  wire logic                            rst_i,
    input  wire logic                            ext_mode_i,
    input  wire logic                            instr_valid_i,
    input  wire logic [ext_exec_pkg::WORD_W-1:0] instr_word_i,
    input  wire logic                            fp_load_i,
    input  wire logic [ext_exec_pkg::FP_W-1:0]   fp_load_data_i,
    input  wire logic [ext_exec_pkg::PC_W-1:0]   top_of_return_stack_i,
    input  wire logic [ext_exec_pkg::DATA_W-1:0] mem_rd_data_i,
    output logic      [1:0]                      phase_o,
    output logic                                 busy_o,
    output logic                                 decode_hit_o,
    output logic                                 nop_cycle_o,
    output logic      [ext_exec_pkg::FP_W-1:0]   frame_pointer_o,
    output logic                                 pc_load_o,
    output logic      [ext_exec_pkg::PC_W-1:0]   program_counter_o,
    output logic                                 stack_pop_o,
    output logic                                 mem_rd_o,
    output logic      [ext_exec_pkg::DADDR_W-1:0] mem_rd_addr_o,
    output logic                                 mem_wr_o,
    output logic      [ext_exec_pkg::DADDR_W-1:0] mem_wr_addr_o,
    output logic      [ext_exec_pkg::DATA_W-1:0] mem_wr_data_o,
    output logic                                 status_write_o
);
    import ext_exec_pkg::*;

    typedef struct packed {
        logic [1:0]         phase;
        exec_state_t        st;
        logic [ZS_W-1:0]    operand;
        logic [FP_W-1:0]    fp;
        logic [DADDR_W-1:0] src_addr;
        logic [DADDR_W-1:0] dst_addr;
        logic [DATA_W-1:0]  src_data;
        logic               dst_ok;
        logic               hit;
        logic               pc_load;
        logic [PC_W-1:0]    pc;
        logic               pop;
        logic               rd;
        logic               wr;
        logic               status_we;
    } exec_regs_t;

    localparam exec_regs_t REGS_RESET = '{
        phase:     PH_RESET,
        st:        ST_FETCH,
        operand:   OPND_RESET,
        fp:        FP_RESET,
        src_addr:  ADDR_RESET,
        dst_addr:  ADDR_RESET,
        src_data:  DATA_RESET,
        dst_ok:    1'b0,
        hit:       1'b0,
        pc_load:   1'b0,
        pc:        PC_RESET,
        pop:       1'b0,
        rd:        1'b0,
        wr:        1'b0,
        status_we: 1'b0
    };

    exec_regs_t s_reg;
    exec_regs_t s_next;

    logic               at_decode;
    logic               is_add_ret;
    logic               is_move;
    logic               is_trail;
    logic [FP_W-1:0]    fp_plus_k;
    logic [FP_W-1:0]    fp_plus_zs;

    ////////////////////////////////////////////////////////////////////////////
    // decode of the presented word
    assign at_decode  = (s_reg.phase == PH_DECODE) && instr_valid_i;
    assign is_add_ret = ext_mode_i
                        && (instr_word_i[WORD_W-1:OPC_HI_LSB] == OPC_ADD_RET_HI)
                        && (instr_word_i[OPC_HI_LSB-1:OPC_TAG_LSB] == OPC_ADD_RET_TAG);
    assign is_move    = ext_mode_i
                        && (instr_word_i[WORD_W-1:OPC_HI_LSB] == OPC_MOVE_HI)
                        && (instr_word_i[OPC_ZS_TAG_BIT] == OPC_MOVE_ZS_TAG);
    assign is_trail   = ext_mode_i
                        && (instr_word_i[WORD_W-1:OPC_NIB_LSB] == OPC_TRAIL_NIB);

    // unsigned literal, zero-extended
    assign fp_plus_k  = s_reg.fp + {{(FP_W-K_W){1'b0}}, s_reg.operand[K_W-1:0]};
    assign fp_plus_zs = s_reg.fp + {{(FP_W-ZS_W){1'b0}}, s_reg.operand};

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_next           = s_reg;
        s_next.phase     = s_reg.phase + 2'h1;
        s_next.hit       = 1'b0;
        s_next.pc_load   = 1'b0;
        s_next.pop       = 1'b0;
        s_next.rd        = 1'b0;
        s_next.wr        = 1'b0;
        s_next.status_we = 1'b0;

        if (fp_load_i) begin
            s_next.fp = fp_load_data_i;
        end

        case (s_reg.st)
            ST_FETCH: begin
                if (at_decode) begin
                    if (is_add_ret) begin
                        s_next.hit     = 1'b1;
                        s_next.operand = {1'b0, instr_word_i[K_W-1:0]};
                        s_next.st      = ST_ADD_EXEC;
                    end else if (is_move) begin
                        s_next.hit     = 1'b1;
                        s_next.operand = instr_word_i[ZS_W-1:0];
                        s_next.st      = ST_MOVE_SRC;
                    end else if (is_trail) begin
                        s_next.hit     = 1'b1;
                    end
                end
            end
            ST_ADD_EXEC: begin
                if (s_reg.phase == PH_PROC) begin
                    s_next.fp      = fp_plus_k;
                    s_next.pc_load = 1'b1;
                    s_next.pc      = top_of_return_stack_i;
                    s_next.pop     = 1'b1;
                end
                if (s_reg.phase == PH_WRITE) begin
                    s_next.st = ST_ADD_NOP;
                end
            end
            ST_ADD_NOP: begin
                // word fetched in this cycle is discarded
                if (s_reg.phase == PH_WRITE) begin
                    s_next.st = ST_FETCH;
                end
            end
            ST_MOVE_SRC: begin
                if (s_reg.phase == PH_READ) begin
                    s_next.src_addr = fp_plus_zs[DADDR_W-1:0];
                end
                if (s_reg.phase == PH_PROC) begin
                    s_next.rd = 1'b1;
                end
                if (s_reg.phase == PH_WRITE) begin
                    s_next.st     = ST_MOVE_DEST;
                    s_next.dst_ok = 1'b0;
                end
            end
            ST_MOVE_DEST: begin
                if (s_reg.phase == PH_DECODE) begin
                    s_next.src_data = mem_rd_data_i;
                    if (instr_valid_i && (instr_word_i[WORD_W-1:OPC_NIB_LSB] == OPC_TRAIL_NIB)) begin
                        s_next.dst_addr = instr_word_i[DADDR_W-1:0];
                        s_next.dst_ok   = 1'b1;
                    end
                end
                if ((s_reg.phase == PH_PROC) && s_reg.dst_ok) begin
                    s_next.wr = 1'b1;
                end
                if (s_reg.phase == PH_WRITE) begin
                    s_next.st = ST_FETCH;
                end
            end
            default: begin
                s_next.st = ST_FETCH;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= REGS_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign phase_o           = s_reg.phase;
    assign busy_o            = (s_reg.st != ST_FETCH);
    assign decode_hit_o      = s_reg.hit;
    assign nop_cycle_o       = (s_reg.st == ST_ADD_NOP);
    assign frame_pointer_o   = s_reg.fp;
    assign pc_load_o         = s_reg.pc_load;
    assign program_counter_o = s_reg.pc;
    assign stack_pop_o       = s_reg.pop;
    assign mem_rd_o          = s_reg.rd;
    assign mem_rd_addr_o     = s_reg.src_addr;
    assign mem_wr_o          = s_reg.wr;
    assign mem_wr_addr_o     = s_reg.dst_addr;
    assign mem_wr_data_o     = s_reg.src_data;
    assign status_write_o    = s_reg.status_we;

endmodule // extended_stack_instr_exec

/* tb/exec_chk_sva.sv */
/* assertions for the extended-instruction executor
   assumes binding to the top ports, one clock domain */
`timescale 1ns/1ps
module exec_chk import ext_exec_pkg::*; (
    input wire logic               core_clk_i,
    input wire logic               rst_i,
    input wire logic               ext_mode_i,
    input wire logic               instr_valid_i,
    input wire logic [WORD_W-1:0]  instr_word_i,
    input wire logic [PC_W-1:0]    top_of_return_stack_i,
    input wire logic [DATA_W-1:0]  mem_rd_data_i,
    input wire logic [1:0]         phase_o,
    input wire logic               busy_o,
    input wire logic               decode_hit_o,
    input wire logic               nop_cycle_o,
    input wire logic [FP_W-1:0]    frame_pointer_o,
    input wire logic               pc_load_o,
    input wire logic [PC_W-1:0]    program_counter_o,
    input wire logic               stack_pop_o,
    input wire logic               mem_rd_o,
    input wire logic [DADDR_W-1:0] mem_rd_addr_o,
    input wire logic               mem_wr_o,
    input wire logic [DADDR_W-1:0] mem_wr_addr_o,
    input wire logic [DATA_W-1:0]  mem_wr_data_o,
    input wire logic               status_write_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic dec;
    assign dec = phase_o == 2'h0 && instr_valid_i && ext_mode_i && !busy_o;
    ////////////////////////////////////////////////////////////////////////////
    property p_add; dec && instr_word_i[15:6] == 10'h3A3 |-> ##3 pc_load_o &&
        frame_pointer_o == $past(frame_pointer_o) + $past(instr_word_i[5:0], 3); endproperty
    a_add: assert property (p_add) else $error("frame pointer add wrong");
    property p_ret; pc_load_o |-> stack_pop_o && phase_o == 2'h3 &&
        program_counter_o == $past(top_of_return_stack_i); endproperty
    a_ret: assert property (p_ret) else $error("return load wrong");
    property p_nop; pc_load_o |=> nop_cycle_o [*4] ##1 !busy_o && !nop_cycle_o; endproperty
    a_nop: assert property (p_nop) else $error("idle cycle wrong");
    property p_src; dec && instr_word_i[15:7] == 9'h1D6 |-> ##3 mem_rd_o &&
        mem_rd_addr_o == 12'($past(frame_pointer_o, 3) + $past(instr_word_i[6:0], 3)); endproperty
    a_src: assert property (p_src) else $error("source address wrong");
    property p_dst; mem_wr_o |-> phase_o == 2'h3 && $past(instr_word_i[15:12], 3) == 4'hF &&
        mem_wr_addr_o == $past(instr_word_i[11:0], 3) && mem_wr_data_o == $past(mem_rd_data_i, 3); endproperty
    a_dst: assert property (p_dst) else $error("move write wrong");
    property p_len; mem_rd_o |-> ##4 busy_o ##1 !busy_o; endproperty
    a_len: assert property (p_len) else $error("move length wrong");
    property p_mode; phase_o == 2'h0 && !ext_mode_i |=> !decode_hit_o; endproperty
    a_mode: assert property (p_mode) else $error("decoded while disabled");
    property p_trail; dec && instr_word_i[15:12] == 4'hF |=> decode_hit_o && !busy_o; endproperty
    a_trail: assert property (p_trail) else $error("lone word not idle");
    property p_flags; !status_write_o; endproperty
    a_flags: assert property (p_flags) else $error("status written");
    c_ret: cover property (pc_load_o);
    c_wr: cover property (mem_wr_o);
    c_trail: cover property (decode_hit_o && !busy_o);
endmodule // exec_chk

/* tb/data_mem_model.sv */
/* data memory on the far side of the executor
   assumes one clock of read latency */
`timescale 1ns/1ps
module data_mem_model import ext_exec_pkg::*; (
    input  wire logic               clk_i,
    input  wire logic               rd_i,
    input  wire logic [DADDR_W-1:0] rd_addr_i,
    input  wire logic               wr_i,
    input  wire logic [DADDR_W-1:0] wr_addr_i,
    input  wire logic [DATA_W-1:0]  wr_data_i,
    output logic      [DATA_W-1:0]  rd_data_o
);
    logic [DATA_W-1:0] mem [4096];
    initial begin
        for (int a = 0; a < 4096; a++) begin
            mem[a] = a[7:0] ^ 8'h5A;
        end
        rd_data_o = 8'h00;
    end
    // data valid one clock after a read, scrambled otherwise
    always @(posedge clk_i) begin
        rd_data_o <= rd_i ? mem[rd_addr_i] : ~rd_data_o;
        if (wr_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end
endmodule // data_mem_model

/* tb/extended_stack_instr_exec_tb.sv */
/* bench for the extended-instruction executor
   assumes data_mem_model on the memory side */
`timescale 1ns/1ps
module extended_stack_instr_exec_tb;
    import ext_exec_pkg::*;
    logic core_clk_i = 0, rst_i = 1, ext_mode_i = 1, instr_valid_i = 0, fp_load_i = 0;
    logic [15:0] instr_word_i = 0;
    logic [13:0] fp_load_data_i = 0, f, fe;
    logic [20:0] top_of_return_stack_i = 0, t, program_counter_o;
    logic [5:0]  k;
    logic [7:0]  mem_rd_data_i, mem_wr_data_o;
    logic [11:0] mem_rd_addr_o, mem_wr_addr_o;
    logic [13:0] frame_pointer_o;
    logic [1:0]  phase_o;
    logic busy_o, decode_hit_o, nop_cycle_o, pc_load_o, stack_pop_o, mem_rd_o, mem_wr_o, status_write_o;
    int bad_count = 0, n_compared = 0;
    // rows: frame pointer, literal, top of return stack, expected frame pointer
    logic [54:0] rows [4] = '{{14'h03FF, 6'h23, 21'h00100, 14'h0422}, {14'h0000, 6'h00, 21'h1FFFFF, 14'h0000},
                              {14'h3FFF, 6'h3F, 21'h0ABCDE, 14'h003E}, {14'h1234, 6'h01, 21'h000000, 14'h1235}};
    extended_stack_instr_exec dut (.core_clk_i, .rst_i, .ext_mode_i, .instr_valid_i, .instr_word_i,
        .fp_load_i, .fp_load_data_i, .top_of_return_stack_i, .mem_rd_data_i, .phase_o, .busy_o,
        .decode_hit_o, .nop_cycle_o, .frame_pointer_o, .pc_load_o, .program_counter_o, .stack_pop_o,
        .mem_rd_o, .mem_rd_addr_o, .mem_wr_o, .mem_wr_addr_o, .mem_wr_data_o, .status_write_o);
    data_mem_model mem_model (.clk_i(core_clk_i), .rd_i(mem_rd_o), .rd_addr_i(mem_rd_addr_o),
        .wr_i(mem_wr_o), .wr_addr_i(mem_wr_addr_o), .wr_data_i(mem_wr_data_o), .rd_data_o(mem_rd_data_i));
    always #25 core_clk_i = ~core_clk_i;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic put(input logic [15:0] w, input logic idle);
        while (phase_o !== 2'h0 || (idle && busy_o !== 1'b0)) tick(1);
        instr_valid_i = 1;
        instr_word_i = w;
        tick(1);
        instr_valid_i = 0;
    endtask
    task automatic setfp(input logic [13:0] v);
        fp_load_i = 1;
        fp_load_data_i = v;
        tick(1);
        fp_load_i = 0;
    endtask
    task automatic mv(input logic [13:0] fv, input logic [6:0] z, input logic [15:0] w2, input logic wr);
        logic [11:0] s;
        logic seen;
        s = 12'(fv + z);
        seen = 0;
        setfp(fv);
        put({9'h1D6, z}, 1);
        put(w2, 0);
        repeat (5) begin
            if (mem_wr_o === 1'b1) begin
                seen = 1;
                chk(mem_wr_addr_o, w2[11:0]);
                chk(mem_wr_data_o, s[7:0] ^ 8'h5A);
            end
            tick(1);
        end
        chk(seen, wr);
        chk(frame_pointer_o, fv);
        chk(status_write_o, 1'h0);
    endtask
    task automatic conclude;
        if (bad_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(8);
        chk(frame_pointer_o, 0);
        chk(busy_o, 0);
        rst_i = 0;
        for (int i = 0; i < 4; i++) begin
            {f, k, t, fe} = rows[i];
            setfp(f);
            top_of_return_stack_i = t;
            put({10'h3A3, k}, 1);
            chk(decode_hit_o, 1);
            tick(7);
            chk(frame_pointer_o, fe);
            chk(program_counter_o, t);
            chk(busy_o, 0);
        end
        mv(14'h0F80, 7'h7F, 16'hFABC, 1);
        mv(14'h1FF0, 7'h20, 16'hFFFF, 1);
        mv(14'h0100, 7'h05, 16'hE105, 0);
        ext_mode_i = 0;
        put(16'hE8C5, 1);
        chk(decode_hit_o, 0);
        tick(7);
        chk(frame_pointer_o, 14'h0100);
        ext_mode_i = 1;
        put(16'hF123, 1);
        chk(decode_hit_o, 1);
        chk(busy_o, 0);
        // core load of the frame pointer in the add clock loses to the add
        setfp(14'h0010);
        put({10'h3A3, 6'h02}, 1);
        tick(1);
        setfp(14'h2000);
        tick(5);
        chk(frame_pointer_o, 14'h0012);
        chk(busy_o, 1'h0);
        chk(status_write_o, 1'h0);
        // reset in the middle of an add-and-return
        put({10'h3A3, 6'h3F}, 1);
        tick(1);
        rst_i = 1;
        tick(2);
        chk(busy_o, 1'h0);
        chk(frame_pointer_o, 14'h0000);
        chk(phase_o, 2'h0);
        chk(pc_load_o, 1'h0);
        rst_i = 0;
        tick(1);
        chk(phase_o, 2'h1);
        chk(busy_o, 1'h0);
        // first instruction after the release starts from a cleared pointer
        put({10'h3A3, 6'h05}, 1);
        chk(decode_hit_o, 1'h1);
        tick(7);
        chk(frame_pointer_o, 14'h0005);
        chk(busy_o, 1'h0);
        conclude();
    end
    initial begin
        #50000;
        bad_count++;
        conclude();
    end
endmodule // extended_stack_instr_exec_tb
bind extended_stack_instr_exec exec_chk u_chk (.core_clk_i, .rst_i, .ext_mode_i, .instr_valid_i,
    .instr_word_i, .top_of_return_stack_i, .mem_rd_data_i, .phase_o, .busy_o, .decode_hit_o,
    .nop_cycle_o, .frame_pointer_o, .pc_load_o, .program_counter_o, .stack_pop_o, .mem_rd_o,
    .mem_rd_addr_o, .mem_wr_o, .mem_wr_addr_o, .mem_wr_data_o, .status_write_o);
